// ===== pkg/lcd_timing_pkg.sv
// Register map, field layout, reset values, divider decoding and the strobe
// carrier of the LCD timing generator.
// Assumes an APB slave with 32-bit data, one aligned word per register, and
// a real-time-clock oscillator that reaches the block as a plain pin.
//
// Functional notes
// - A charge pump cycle starts every pump_cycle_period plus one oscillator periods.
// - The two reserved top bits of pump_cycle_config read as 10 and software writes 10.
// - All LCD refresh and toggle timing runs from the oscillator divided by two.
// - The 10-bit refresh_prescaler holds bits 9:8 in the high and 7:0 in the low register.
// - Refresh rate is oscillator frequency over 4 times backplanes times prescaler plus one.
// - Toggle rate is refresh rate times backplanes times 2 over the toggle divider.
// - Toggle codes 0010 to 1000 divide by the powers of two from 2 to 128.
// - Toggle code 1001 divides by 125 as printed.
// - Toggle codes 1010 to 1101 divide by 512, 1024, 2048 and 4096.
// - Unused top bits of the high prescaler and toggle registers read zero, writes ignored.
// - The backplane count is one to four after backplane_count_select 00 to 11.
// - Segments set in the blink mask turn on and off at the toggle rate by themselves.
package lcd_timing_pkg;
   // ************************************************************
   // Register indices; the byte address is four times the index.
   // ************************************************************
   localparam int unsigned APB_AW          = 12;
   localparam logic [7:0]  IDX_PUMP_CFG    = 8'h97;
   localparam logic [7:0]  IDX_PRESC_HIGH  = 8'h98;
   localparam logic [7:0]  IDX_PRESC_LOW   = 8'h99;
   localparam logic [7:0]  IDX_TOGGLE_DIV  = 8'h9A;
   localparam logic [7:0]  IDX_MUX_SELECT  = 8'h9C;
   localparam logic [7:0]  IDX_TIMING_STAT = 8'h9D;

   // ************************************************************
   // Field widths and reset values
   // ************************************************************
   localparam int unsigned PUMP_PER_W    = 6;
   localparam int unsigned PRESC_W       = 10;
   localparam int unsigned PRESC_HI_W    = 2;
   localparam int unsigned PRESC_LO_W    = 8;
   localparam int unsigned TOG_CODE_W    = 4;
   localparam int unsigned MUX_W         = 2;
   localparam int unsigned TOG_CNT_W     = 12;
   localparam int unsigned FRAME_CNT_W   = 3;
   localparam logic [1:0]  PUMP_RSVD_VAL = 2'b10;
   localparam logic [5:0]  PUMP_PER_RST  = 6'h1F;
   localparam logic [9:0]  PRESC_RST     = 10'h000;
   localparam logic [3:0]  TOG_CODE_RST  = 4'h0;
   localparam logic [1:0]  MUX_RST       = 2'h0;

   // ************************************************************
   // Toggle divider codes
   // ************************************************************
   localparam logic [3:0]           TOG_CODE_MIN = 4'h2;
   localparam logic [3:0]           TOG_CODE_MAX = 4'hD;
   localparam logic [3:0]           TOG_CODE_ODD = 4'h9;
   localparam logic [TOG_CNT_W-1:0] TOG_ODD_M1   = 12'h07C;

   function automatic logic [APB_AW-1:0] reg_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   // Divisor minus one. Reserved codes behave as the smallest legal code.
   function automatic logic [TOG_CNT_W-1:0] toggle_m1(input logic [3:0] code);
      logic [3:0] c;
      c = (code < TOG_CODE_MIN || code > TOG_CODE_MAX) ? TOG_CODE_MIN : code;
      if (c == TOG_CODE_ODD) begin
         return TOG_ODD_M1;
      end
      return TOG_CNT_W'((13'h1 << (c - 4'h1)) - 13'h1);
   endfunction

   // A frame is two half-phases per backplane, counted in prescaler strobes.
   function automatic logic [FRAME_CNT_W-1:0] frame_m1(input logic [1:0] sel);
      return {sel, 1'b1};
   endfunction

   typedef struct packed {
      logic pump_start;
      logic com_step;
      logic refresh;
      logic toggle;
   } lcd_strobes_t;
endpackage

// ===== core/lcd_rate_divider.sv
// Programmable event divider: one strobe per period_m1 plus one input ticks.
// Assumes tick is a one-cycle pulse on pclk and that ticks are never adjacent.
`timescale 1ns/1ps
module lcd_rate_divider #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Counting
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] period_m1,
   output logic                  strobe
);
   import lcd_timing_pkg::*;

   if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("lcd_rate_divider width out of range");
   end

   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH-1:0] cnt_nxt;
   logic             strobe_r;
   logic             strobe_nxt;

   // The period is sampled only on reload, so a new value never cuts a period short.
   always_comb begin
      cnt_nxt    = cnt_r;
      strobe_nxt = 1'b0;
      if (tick) begin
         if (cnt_r == '0) begin
            cnt_nxt    = period_m1;
            strobe_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r    <= '0;
         strobe_r <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         strobe_r <= strobe_nxt;
      end
   end

   assign strobe = strobe_r;

   chk_count_holds_period: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && cnt_r != '0) |=> (cnt_r == $past(cnt_r) - 1'b1) && !strobe_r)
      else $error("divider reloaded before its period ended");
endmodule

// ===== core/lcd_timing_generator.sv
// LCD timing generator: APB registers, oscillator synchroniser and the charge
// pump, refresh and toggle strobes with the blink phase.
// Assumes an APB master on pclk and a free-running oscillator pin far slower
// than pclk; the blink mask comes from logic on pclk.
`timescale 1ns/1ps
module lcd_timing_generator (
   // Clock and reset
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   // APB slave
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [lcd_timing_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                       pwdata,
   input  wire logic [3:0]                        pstrb,
   output logic      [31:0]                       prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // Oscillator pin
   input  wire logic                              rtc_osc,
   // Blink
   input  wire logic [7:0]                        segment_blink_mask,
   output logic      [7:0]                        blink_off_mask,
   output logic                                   blink_phase,
   // Strobes to the waveform generator and charge pump
   output lcd_timing_pkg::lcd_strobes_t           strobes
);
   import lcd_timing_pkg::*;

   // ************************************************************
   // Register file and APB slave
   // ************************************************************
   logic [PUMP_PER_W-1:0] pump_period_r;
   logic [PUMP_PER_W-1:0] pump_period_nxt;
   logic [PRESC_W-1:0]    presc_r;
   logic [PRESC_W-1:0]    presc_nxt;
   logic [TOG_CODE_W-1:0] tog_code_r;
   logic [TOG_CODE_W-1:0] tog_code_nxt;
   logic [MUX_W-1:0]      mux_r;
   logic [MUX_W-1:0]      mux_nxt;
   logic [31:0]           prdata_r;
   logic [31:0]           prdata_nxt;
   logic                  pready_r;
   logic                  pready_nxt;
   logic                  pslverr_r;
   logic                  pslverr_nxt;
   logic [31:0]           rd_data;
   logic                  rd_hit;
   logic                  wr_en;
   logic                  lvl_r;
   logic                  blink_phase_r;

   // Read data and decode are both resolved in the setup cycle.
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (paddr)
         reg_addr(IDX_PUMP_CFG):    rd_data = {24'h00_0000, PUMP_RSVD_VAL, pump_period_r};
         reg_addr(IDX_PRESC_HIGH):  rd_data = {30'h0000_0000, presc_r[9:8]};
         reg_addr(IDX_PRESC_LOW):   rd_data = {24'h00_0000, presc_r[7:0]};
         reg_addr(IDX_TOGGLE_DIV):  rd_data = {28'h000_0000, tog_code_r};
         reg_addr(IDX_MUX_SELECT):  rd_data = {30'h0000_0000, mux_r};
         reg_addr(IDX_TIMING_STAT): rd_data = {30'h0000_0000, lvl_r, blink_phase_r};
         default:                   rd_hit  = 1'b0;
      endcase
   end

   assign wr_en = psel && penable && pready_r && pwrite && pstrb[0] && rd_hit;

   always_comb begin
      pump_period_nxt = pump_period_r;
      presc_nxt       = presc_r;
      tog_code_nxt    = tog_code_r;
      mux_nxt         = mux_r;
      pready_nxt      = psel && !penable;
      pslverr_nxt     = psel && !penable && !rd_hit;
      prdata_nxt      = (psel && !penable) ? rd_data : prdata_r;
      if (wr_en) begin
         case (paddr)
            reg_addr(IDX_PUMP_CFG):   pump_period_nxt = pwdata[PUMP_PER_W-1:0];
            reg_addr(IDX_PRESC_HIGH): presc_nxt[9:8] = pwdata[PRESC_HI_W-1:0];
            reg_addr(IDX_PRESC_LOW):  presc_nxt[7:0] = pwdata[PRESC_LO_W-1:0];
            reg_addr(IDX_TOGGLE_DIV): tog_code_nxt = pwdata[TOG_CODE_W-1:0];
            reg_addr(IDX_MUX_SELECT): mux_nxt = pwdata[MUX_W-1:0];
            default:                  mux_nxt = mux_r;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_period_r <= PUMP_PER_RST;
         presc_r       <= PRESC_RST;
         tog_code_r    <= TOG_CODE_RST;
         mux_r         <= MUX_RST;
         prdata_r      <= 32'h0000_0000;
         pready_r      <= 1'b0;
         pslverr_r     <= 1'b0;
      end else begin
         pump_period_r <= pump_period_nxt;
         presc_r       <= presc_nxt;
         tog_code_r    <= tog_code_nxt;
         mux_r         <= mux_nxt;
         prdata_r      <= prdata_nxt;
         pready_r      <= pready_nxt;
         pslverr_r     <= pslverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

   // ************************************************************
   // Oscillator synchroniser and divide by two
   // ************************************************************
   logic sync1_r;
   logic sync2_r;
   logic sync3_r;
   logic lvl_nxt;
   logic osc_tick_r;
   logic osc_tick_nxt;
   logic half_r;
   logic half_nxt;
   logic half_tick;

   // A level counts only once two late stages agree, so a metastable sample
   // can never produce a spurious oscillator edge.
   always_comb begin
      lvl_nxt      = (sync2_r == sync3_r) ? sync3_r : lvl_r;
      osc_tick_nxt = lvl_nxt && !lvl_r;
      half_nxt     = osc_tick_r ? !half_r : half_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r    <= 1'b0;
         sync2_r    <= 1'b0;
         sync3_r    <= 1'b0;
         lvl_r      <= 1'b0;
         osc_tick_r <= 1'b0;
         half_r     <= 1'b0;
      end else begin
         sync1_r    <= rtc_osc;
         sync2_r    <= sync1_r;
         sync3_r    <= sync2_r;
         lvl_r      <= lvl_nxt;
         osc_tick_r <= osc_tick_nxt;
         half_r     <= half_nxt;
      end
   end

   assign half_tick = osc_tick_r && half_r;

   // ************************************************************
   // Rate dividers
   // ************************************************************
   logic                   pump_s;
   logic                   presc_s;
   logic                   frame_s;
   logic                   tog_s;
   logic [FRAME_CNT_W-1:0] frame_per;
   logic [TOG_CNT_W-1:0]   tog_per;

   assign frame_per = frame_m1(mux_r);
   assign tog_per   = toggle_m1(tog_code_r);

   lcd_rate_divider #(.WIDTH(PUMP_PER_W)) u_pump (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (osc_tick_r),
      .period_m1 (pump_period_r),
      .strobe    (pump_s)
   );

   lcd_rate_divider #(.WIDTH(PRESC_W)) u_presc (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (half_tick),
      .period_m1 (presc_r),
      .strobe    (presc_s)
   );

   lcd_rate_divider #(.WIDTH(FRAME_CNT_W)) u_frame (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (presc_s),
      .period_m1 (frame_per),
      .strobe    (frame_s)
   );

   lcd_rate_divider #(.WIDTH(TOG_CNT_W)) u_toggle (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (presc_s),
      .period_m1 (tog_per),
      .strobe    (tog_s)
   );

   // ************************************************************
   // Output strobes and blink phase
   // ************************************************************
   lcd_strobes_t strobes_r;
   lcd_strobes_t strobes_nxt;
   logic         blink_phase_nxt;
   logic [7:0]   blink_off_r;
   logic [7:0]   blink_off_nxt;

   always_comb begin
      strobes_nxt.pump_start = pump_s;
      strobes_nxt.com_step   = presc_s;
      strobes_nxt.refresh    = frame_s;
      strobes_nxt.toggle     = tog_s;
      blink_phase_nxt        = tog_s ? !blink_phase_r : blink_phase_r;
      blink_off_nxt          = segment_blink_mask & {8{blink_phase_r}};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobes_r     <= '0;
         blink_phase_r <= 1'b0;
         blink_off_r   <= 8'h00;
      end else begin
         strobes_r     <= strobes_nxt;
         blink_phase_r <= blink_phase_nxt;
         blink_off_r   <= blink_off_nxt;
      end
   end

   assign strobes        = strobes_r;
   assign blink_phase    = blink_phase_r;
   assign blink_off_mask = blink_off_r;

   // ************************************************************
   // Checks
   // ************************************************************
   logic [6:0]  osc_since_pump;
   logic [5:0]  pump_per_d;
   logic [5:0]  pump_per_q;
   logic [1:0]  osc_since_half;
   logic [10:0] half_since_presc;
   logic [9:0]  presc_d;
   logic [9:0]  presc_q;
   logic [3:0]  presc_since_frame;
   logic [2:0]  frame_d;
   logic [2:0]  frame_q;
   logic [12:0] presc_since_tog;
   logic [11:0] tog_d;
   logic [11:0] tog_q;
   logic [3:0]  seen;

   // Each period figure is latched one cycle late, matching the reload edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {osc_since_pump, pump_per_d, pump_per_q, osc_since_half} <= '0;
         {half_since_presc, presc_d, presc_q} <= '0;
         {presc_since_frame, frame_d, frame_q} <= '0;
         {presc_since_tog, tog_d, tog_q, seen} <= '0;
      end else begin
         pump_per_d <= pump_period_r;
         presc_d    <= presc_r;
         frame_d    <= frame_per;
         tog_d      <= tog_per;
         seen       <= seen | {tog_s, frame_s, presc_s, pump_s};
         if (pump_s) begin
            osc_since_pump <= 7'h00;
            pump_per_q     <= pump_per_d;
         end else if (osc_tick_r) begin
            osc_since_pump <= osc_since_pump + 7'h01;
         end
         if (half_tick) begin
            osc_since_half <= 2'h0;
         end else if (osc_tick_r) begin
            osc_since_half <= osc_since_half + 2'h1;
         end
         if (presc_s) begin
            half_since_presc <= 11'h000;
            presc_q          <= presc_d;
         end else if (half_tick) begin
            half_since_presc <= half_since_presc + 11'h001;
         end
         if (frame_s) begin
            presc_since_frame <= 4'h0;
            frame_q           <= frame_d;
         end else if (presc_s) begin
            presc_since_frame <= presc_since_frame + 4'h1;
         end
         if (tog_s) begin
            presc_since_tog <= 13'h0000;
            tog_q           <= tog_d;
         end else if (presc_s) begin
            presc_since_tog <= presc_since_tog + 13'h0001;
         end
      end
   end

   chk_pump_rsvd_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && !pwrite && paddr == reg_addr(IDX_PUMP_CFG))
      |-> prdata[7:6] == PUMP_RSVD_VAL && prdata[31:8] == '0)
      else $error("pump config reserved bits read wrong");

   chk_high_unused_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && paddr == reg_addr(IDX_PRESC_HIGH))
      |-> prdata[31:2] == '0 && prdata[1:0] == presc_r[9:8])
      else $error("high prescaler read shows unused bits");

   chk_toggle_unused_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && paddr == reg_addr(IDX_TOGGLE_DIV))
      |-> prdata[31:4] == '0)
      else $error("toggle divider read shows unused bits");

   chk_half_rate: assert property (
      @(posedge pclk) disable iff (!presetn)
      half_tick |-> osc_since_half == 2'h1)
      else $error("half rate tick not every second oscillator period");

   chk_pump_period: assert property (
      @(posedge pclk) disable iff (!presetn)
      (strobes_nxt.pump_start && seen[0]) |-> osc_since_pump == pump_per_q + 7'h01)
      else $error("pump cycle spacing wrong");

   chk_presc_period: assert property (
      @(posedge pclk) disable iff (!presetn)
      (presc_s && seen[1]) |-> half_since_presc == presc_q + 11'h001)
      else $error("prescaler period wrong");

   chk_frame_length: assert property (
      @(posedge pclk) disable iff (!presetn)
      (frame_s && seen[2]) |-> presc_since_frame == frame_q + 4'h1)
      else $error("refresh frame length wrong");

   chk_toggle_length: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tog_s && seen[3]) |-> presc_since_tog == tog_q + 13'h0001)
      else $error("toggle period wrong");

   chk_blink_follows: assert property (
      @(posedge pclk) disable iff (!presetn)
      strobes.toggle |-> blink_phase != $past(blink_phase)
      ##1 blink_off_mask == ($past(segment_blink_mask) & {8{$past(blink_phase)}}))
      else $error("blink phase does not follow toggle");
endmodule

// ===== dv/lcd_far_side.sv
// Far-side model: oscillator source plus waveform and pump timing monitor.
// Assumes the strobes are one-cycle pulses on pclk.
`timescale 1ns/1ps
module lcd_far_side (
   // Clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // From the generator
   input  wire lcd_timing_pkg::lcd_strobes_t  strobes,
   // Oscillator pin
   output logic                               rtc_osc,
   // Event counts and last intervals in pclk cycles
   output logic [31:0]                        cnt [4],
   output logic [31:0]                        period [4]
);
   import lcd_timing_pkg::*;
   logic [3:0]  s;
   logic [31:0] now_r;
   logic [31:0] last_r [4];
   logic [1:0]  osc_div_r;
   assign s = strobes;
   // The oscillator free-runs; an 8-cycle period keeps each level well above the sync depth.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         now_r     <= '0;
         osc_div_r <= '0;
         rtc_osc   <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            cnt[i]    <= '0;
            period[i] <= '0;
            last_r[i] <= '0;
         end
      end else begin
         now_r     <= now_r + 32'h0000_0001;
         osc_div_r <= osc_div_r + 2'h1;
         if (osc_div_r == 2'h3) begin
            rtc_osc <= ~rtc_osc;
         end
         for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
               cnt[i]    <= cnt[i] + 32'h0000_0001;
               period[i] <= now_r - last_r[i];
               last_r[i] <= now_r;
            end
         end
      end
   end
endmodule

// ===== dv/lcd_timing_generator_test.sv
// Testbench of the LCD timing generator: rate table, registers and reload timing.
// Assumes the far-side model drives an oscillator of 8 pclk periods.
`timescale 1ns/1ps
module lcd_timing_generator_test;
   import lcd_timing_pkg::*;
   typedef struct packed {
      logic [5:0]  pp;
      logic [9:0]  pr;
      logic [3:0]  tc;
      logic [1:0]  sel;
      logic [12:0] div;
   } row_t;
   logic         pclk;
   logic         presetn;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [11:0]  paddr;
   logic [31:0]  pwdata;
   logic [3:0]   pstrb;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         rtc_osc;
   logic [7:0]   mask;
   logic [7:0]   mask_d;
   logic [7:0]   blink_off_mask;
   logic         blink_phase;
   lcd_strobes_t strobes;
   logic [31:0]  cnt [4];
   logic [31:0]  period [4];
   logic [31:0]  rd;
   logic [31:0]  com;
   logic         er;
   logic         phase_exp;
   int           error_cnt;
   int           num_checks;
   row_t rows [9] = '{
      '{6'h00, 10'h000, 4'h2, 2'h0, 13'h0002}, '{6'h05, 10'h001, 4'h3, 2'h1, 13'h0004},
      '{6'h3F, 10'h003, 4'h4, 2'h2, 13'h0008}, '{6'h1F, 10'h000, 4'h5, 2'h3, 13'h0010},
      '{6'h00, 10'h000, 4'h6, 2'h0, 13'h0020}, '{6'h00, 10'h000, 4'h7, 2'h1, 13'h0040},
      '{6'h00, 10'h000, 4'h8, 2'h2, 13'h0080}, '{6'h00, 10'h000, 4'h9, 2'h3, 13'h007D},
      '{6'h00, 10'h000, 4'hA, 2'h0, 13'h0200}};

   lcd_timing_generator uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rtc_osc(rtc_osc), .segment_blink_mask(mask),
      .blink_off_mask(blink_off_mask), .blink_phase(blink_phase), .strobes(strobes));
   lcd_far_side far (.pclk(pclk), .presetn(presetn), .strobes(strobes), .rtc_osc(rtc_osc),
      .cnt(cnt), .period(period));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] st);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= d;
      pstrb   <= st;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      check(n, 32'h0000_0001);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d, 4'hF);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_er);
      apb(1'b0, idx, 32'h0, 4'hF);
      check(rd, exp);
      check({31'h0, er}, {31'h0, exp_er});
   endtask
   // Waits until every selected strobe has fired n more times.
   task automatic wait_adv(input int n, input logic [3:0] m);
      logic [31:0] c [4];
      int          k;
      bit          done;
      c = cnt;
      k = 0;
      done = 0;
      while (!done && k < 40000) begin
         @(posedge pclk);
         k++;
         done = 1;
         for (int i = 0; i < 4; i++) begin
            if (m[i] && cnt[i] - c[i] < n) begin
               done = 0;
            end
         end
      end
      check({31'h0, done}, 32'h0000_0001);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ************************************************************
   // Clock, blink monitor and watchdog
   // ************************************************************
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_exp <= 1'b0;
         mask_d    <= 8'h00;
      end else begin
         phase_exp <= phase_exp ^ strobes.toggle;
         mask_d    <= mask;
      end
   end
   // The phase flips with the toggle strobe and the off mask follows a cycle later.
   // Reset values are checked by hand, so the monitor sleeps while reset is applied.
   always @(negedge pclk) begin
      if (presetn) begin
         check({23'h0, blink_phase, blink_off_mask},
               {23'h0, phase_exp ^ strobes.toggle, mask_d & {8{phase_exp}}});
      end
   end
   initial begin
      #400000;
      error_cnt++;
      end_sim();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      mask = 8'hA5;
      error_cnt = 0;
      num_checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int r = 0; r < 9; r++) begin
         wr(IDX_PUMP_CFG, {24'h0, 2'b10, rows[r].pp});
         wr(IDX_PRESC_HIGH, {30'h0, rows[r].pr[9:8]});
         wr(IDX_PRESC_LOW, {24'h0, rows[r].pr[7:0]});
         wr(IDX_TOGGLE_DIV, {28'h0, rows[r].tc});
         wr(IDX_MUX_SELECT, {30'h0, rows[r].sel});
         wait_adv(3, 4'hF);
         com = 32'h0000_0010 * (rows[r].pr + 32'h0000_0001);
         check(period[3], 32'h0000_0008 * (rows[r].pp + 32'h0000_0001));
         check(period[2], com);
         check(period[1], com * 2 * (rows[r].sel + 32'h0000_0001));
         check(period[0], com * rows[r].div);
      end
      // A second reset mid-run, then a divider change in the middle of a toggle period.
      @(posedge pclk);
      presetn <= 1'b0;
      mask    <= 8'h3C;
      repeat (16) @(posedge pclk);
      check({19'h0, strobes, blink_phase, blink_off_mask}, 32'h0000_0000);
      check({30'h0, pready, pslverr}, 32'h0000_0000);
      presetn <= 1'b1;
      wait_adv(3, 4'hF);
      // Aligning on a toggle event puts the write well inside the following period.
      wait_adv(1, 4'h1);
      wr(IDX_TOGGLE_DIV, 32'h0000_0003);
      wait_adv(1, 4'h1);
      check(period[0], 32'h0000_0020);
      wait_adv(1, 4'h1);
      check(period[0], 32'h0000_0040);
      rd_chk(IDX_PUMP_CFG, 32'h0000_009F, 1'b0);
      rd_chk(IDX_PRESC_LOW, 32'h0000_0000, 1'b0);
      wr(IDX_PRESC_HIGH, 32'h0000_00FF);
      rd_chk(IDX_PRESC_HIGH, 32'h0000_0003, 1'b0);
      wr(IDX_TOGGLE_DIV, 32'h0000_00F2);
      rd_chk(IDX_TOGGLE_DIV, 32'h0000_0002, 1'b0);
      wr(IDX_PRESC_LOW, 32'h0000_00A5);
      apb(1'b1, IDX_PRESC_LOW, 32'h0000_0011, 4'h0);
      rd_chk(IDX_PRESC_LOW, 32'h0000_00A5, 1'b0);
      wr(IDX_PUMP_CFG, 32'h0000_0095);
      rd_chk(IDX_PUMP_CFG, 32'h0000_0095, 1'b0);
      rd_chk(8'h90, 32'h0000_0000, 1'b1);
      end_sim();
   end
endmodule
